// File: pkg/nfc_defs.vh
// Command codes, address layout and bus timing counts for the NAND host controller
`ifndef NFC_DEFS_VH
`define NFC_DEFS_VH

// ----------------------------------------------------------------
// Command codes (I/O8 is the msb)
// ----------------------------------------------------------------
`define NFC_CMD_READ_SETUP   8'h00
`define NFC_CMD_READ_START   8'h30
`define NFC_CMD_COL_OUT      8'h05
`define NFC_CMD_COL_OUT_GO   8'he0
`define NFC_CMD_READ_CACHE   8'h31
`define NFC_CMD_READ_LAST    8'h3f
`define NFC_CMD_COPY_READ    8'h3a
`define NFC_CMD_PROG_SETUP   8'h80
`define NFC_CMD_PROG_PLANE2  8'h81
`define NFC_CMD_COPY_PROG    8'h8c
`define NFC_CMD_COL_IN       8'h85
`define NFC_CMD_PROG_GO      8'h10
`define NFC_CMD_PROG_PLANE1  8'h11
`define NFC_CMD_PROG_CACHE   8'h15
`define NFC_CMD_ERASE_SETUP  8'h60
`define NFC_CMD_ERASE_GO     8'hd0
`define NFC_CMD_STATUS       8'h70
`define NFC_CMD_STATUS_MULTI 8'h71
`define NFC_CMD_RESET        8'hff

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define NFC_PAGE_BYTES       13'd4352
`define NFC_LAST_COL         13'd4351
`define NFC_PAGES_PER_BLOCK  7'd64
`define NFC_BLOCKS           12'd2048
`define NFC_FULL_ADDR_CYC    3'd5
`define NFC_COL_ADDR_CYC     3'd2
`define NFC_STAT_CACHE_RDY   6

// ----------------------------------------------------------------
// Timing: strobe phase length, 25 ns period clock
// ----------------------------------------------------------------
`define NFC_CLK_PERIOD_NS    25
`define NFC_STROBE_LOW_NS    25
`define NFC_STROBE_HIGH_NS   25
`define NFC_WHR_NS           60
`define NFC_LOW_CYC   (((`NFC_STROBE_LOW_NS + `NFC_CLK_PERIOD_NS - 1) / `NFC_CLK_PERIOD_NS))
`define NFC_HIGH_CYC  (((`NFC_STROBE_HIGH_NS + `NFC_CLK_PERIOD_NS - 1) / `NFC_CLK_PERIOD_NS))
`define NFC_WHR_CYC   (((`NFC_WHR_NS + `NFC_CLK_PERIOD_NS - 1) / `NFC_CLK_PERIOD_NS))
// Last count of each phase, sized for the 3-bit phase counter; keep in step with the above
`define NFC_LOW_LAST  3'd0
`define NFC_HIGH_LAST 3'd0
`define NFC_WHR_LAST  3'd2

`endif

// File: design/nfc_host.v
// NAND flash host controller: issues command, address, data-in and read cycles
// ----------------------------------------------------------------
// Summary of operation
// - Host sends five address cycles per full address
// - Column bits 0-7, then 8-12 upper low
// - Row bytes 0-7, 8-15, then bit 16
// - Cycle type set by latch enables
// - Write protect high during program and erase
// - Strobes held high while busy, except status/reset
// - Read 00h addr 30h; column 05h E0h
// - Cached read uses 31h and 3Fh
// - Program 80h addr data 10h; 85h
// - Cache program confirms with 15h
// - Two-plane 80h..11h then 81h..10h/15h
// - Page copy 00h..3Ah then 8Ch..15h/10h
// - Command byte I/O8 msb, I/O1 lsb
// - After 15h end, poll status then reset
// - Never drive bus while device drives
// ----------------------------------------------------------------
`include "nfc_defs.vh"

module nfc_host (
	input  wire        clock,          // 40 MHz system clock
	input  wire        rst,            // Synchronous reset, active high
	input  wire        reqValid,       // Cycle request strobe
	output wire        reqReady,       // Engine idle, request taken
	input  wire [1:0]  reqKind,        // 0 cmd, 1 addr bytes, 2 write data, 3 read data
	input  wire [7:0]  reqCmd,         // Command code for kind 0
	input  wire [12:0] reqCol,         // Column address
	input  wire [16:0] reqRow,         // Row address (block and page)
	input  wire [2:0]  reqAddrCycles,  // 2 (column only) or 5
	input  wire [7:0]  reqData,        // Byte for data input
	input  wire        reqWpHigh,      // Write protect released
	output reg  [7:0]  rdData,         // Byte captured in read cycle
	output reg         rdValid,        // One-cycle pulse with rdData
	output reg         busyErr,        // Set when a refused request was asked
	output reg         chipSelectN,    // Chip select, active low
	output reg         commandLatchEnable, // Command latch enable
	output reg         addressLatchEnable, // Address latch enable
	output reg         writeStrobeN,   // Write strobe, active low
	output reg         outputStrobeN,  // Output strobe, active low
	output reg         writeProtectN,  // Write protect, active low
	input  wire [7:0]  ioIn,           // I/O bus input
	output reg  [7:0]  ioOut,          // I/O bus output
	output reg         ioOeN,          // I/O output enable, low drives
	input  wire        readyBusyN,     // Ready/busy pin from device
	output wire        devBusy         // Filtered busy level
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam [4:0] ST_IDLE  = 5'b00001; // Waiting for a request
	localparam [4:0] ST_SETUP = 5'b00010; // Latches and bus set up
	localparam [4:0] ST_LOW   = 5'b00100; // Strobe low phase
	localparam [4:0] ST_HIGH  = 5'b01000; // Strobe high phase
	localparam [4:0] ST_TURN  = 5'b10000; // Bus turnaround before read

	reg [4:0]  state_r;     // Current state
	reg [4:0]  state_nxt;   // Next state
	reg [2:0]  cnt_r;       // Phase counter
	reg [2:0]  cnt_nxt;     // Next phase counter
	reg [2:0]  byteIdx_r;   // Address cycle index
	reg [2:0]  byteIdx_nxt; // Next address cycle index
	reg [2:0]  lastIdx_r;   // Address cycles to send minus one
	reg [1:0]  kind_r;      // Kind of transfer in flight
	reg [7:0]  cmd_r;       // Latched command
	reg [12:0] col_r;       // Latched column
	reg [16:0] row_r;       // Latched row
	reg [7:0]  data_r;      // Latched write byte
	reg        progBusy_r;  // Program or erase command sent
	reg        busySeen_r;  // Device busy observed since the confirm
	reg [2:0]  rbSync_r;    // Ready/busy synchroniser chain
	reg        busy_r;      // Debounced busy level

	wire cmdAllowedBusy; // Command legal while busy
	wire isProgErase;    // Command starts a program or erase
	wire reqRefused;     // Request refused because device is busy
	reg  [7:0] addrByte; // Byte for current address cycle

	// ----------------------------------------------------------------
	// Ready/busy pin synchroniser
	// ----------------------------------------------------------------
	// Three stages; level accepted when stages two and three agree
	always @(posedge clock) begin
		if (rst) begin
			rbSync_r <= 3'b111;
			busy_r   <= 1'b0;
		end else begin
			rbSync_r <= {rbSync_r[1:0], readyBusyN};
			if (rbSync_r[1] == rbSync_r[2]) begin
				busy_r <= ~rbSync_r[2];
			end
		end
	end
	assign devBusy = busy_r;

	// ----------------------------------------------------------------
	// Request screening
	// ----------------------------------------------------------------
	assign cmdAllowedBusy = (reqCmd == `NFC_CMD_STATUS) ||
		(reqCmd == `NFC_CMD_STATUS_MULTI) || (reqCmd == `NFC_CMD_RESET);
	// Only status or reset may go out while busy; strobes stay high otherwise
	assign reqRefused = busy_r && !(reqKind == 2'd0 && cmdAllowedBusy);
	assign reqReady   = (state_r == ST_IDLE) && !reqRefused;
	assign isProgErase = (reqCmd == `NFC_CMD_PROG_GO) || (reqCmd == `NFC_CMD_PROG_PLANE1) ||
		(reqCmd == `NFC_CMD_PROG_CACHE) || (reqCmd == `NFC_CMD_ERASE_GO);

	// ----------------------------------------------------------------
	// Address byte packing
	// ----------------------------------------------------------------
	// Column low, column high, row low, row mid, row bit 16
	always @* begin
		case (byteIdx_r)
			3'd0:    addrByte = col_r[7:0];
			3'd1:    addrByte = {3'h0, col_r[12:8]};
			3'd2:    addrByte = row_r[7:0];
			3'd3:    addrByte = row_r[15:8];
			default: addrByte = {7'h00, row_r[16]};
		endcase
	end

	// ----------------------------------------------------------------
	// Cycle sequencer
	// ----------------------------------------------------------------
	always @* begin
		state_nxt   = state_r;
		cnt_nxt     = cnt_r;
		byteIdx_nxt = byteIdx_r;
		case (state_r)
			ST_IDLE: begin
				if (reqValid && reqReady) begin
					state_nxt   = ST_SETUP;
					byteIdx_nxt = 3'd0;
				end
			end
			ST_SETUP: begin
				// Reads wait out the write-to-read gap first
				if (kind_r == 2'd3) begin
					state_nxt = ST_TURN;
					cnt_nxt   = 3'd0;
				end else begin
					state_nxt = ST_LOW;
					cnt_nxt   = 3'd0;
				end
			end
			ST_TURN: begin
				if (cnt_r >= `NFC_WHR_LAST) begin
					state_nxt = ST_LOW;
					cnt_nxt   = 3'd0;
				end else begin
					cnt_nxt = cnt_r + 3'd1;
				end
			end
			ST_LOW: begin
				if (cnt_r >= `NFC_LOW_LAST) begin
					state_nxt = ST_HIGH;
					cnt_nxt   = 3'd0;
				end else begin
					cnt_nxt = cnt_r + 3'd1;
				end
			end
			ST_HIGH: begin
				if (cnt_r >= `NFC_HIGH_LAST) begin
					cnt_nxt = 3'd0;
					// Address bursts loop back for the next cycle
					if (kind_r == 2'd1 && byteIdx_r != lastIdx_r) begin
						state_nxt   = ST_LOW;
						byteIdx_nxt = byteIdx_r + 3'd1;
					end else begin
						state_nxt = ST_IDLE;
					end
				end else begin
					cnt_nxt = cnt_r + 3'd1;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers and pin drivers
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			state_r            <= ST_IDLE;
			cnt_r              <= 3'd0;
			byteIdx_r          <= 3'd0;
			lastIdx_r          <= 3'd4;
			kind_r             <= 2'd0;
			cmd_r              <= 8'h00;
			col_r              <= 13'h0000;
			row_r              <= 17'h00000;
			data_r             <= 8'h00;
			progBusy_r         <= 1'b0;
			busySeen_r         <= 1'b0;
			rdData             <= 8'h00;
			rdValid            <= 1'b0;
			busyErr            <= 1'b0;
			chipSelectN        <= 1'b1;
			commandLatchEnable <= 1'b0;
			addressLatchEnable <= 1'b0;
			writeStrobeN       <= 1'b1;
			outputStrobeN      <= 1'b1;
			writeProtectN      <= 1'b0;
			ioOut              <= 8'h00;
			ioOeN              <= 1'b1;
		end else begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			byteIdx_r <= byteIdx_nxt;
			rdValid   <= 1'b0;
			// Flag an attempt the device would not accept
			if (reqValid && state_r == ST_IDLE && reqRefused) begin
				busyErr <= 1'b1;
			end else if (reqValid && reqReady) begin
				busyErr <= 1'b0;
			end
			// Busy only shows a few clocks after the confirm, so wait to see it first
			if (progBusy_r && busy_r) begin
				busySeen_r <= 1'b1;
			end
			// Program/erase busy ends when ready returns; a confirm the device
			// never answers leaves write protect released until busy next comes and goes, or reset
			if (busySeen_r && !busy_r && state_r == ST_IDLE && !(reqValid && reqReady)) begin
				progBusy_r <= 1'b0;
				busySeen_r <= 1'b0;
			end
			// Write protect stays released while program or erase busy
			if (!progBusy_r) begin
				writeProtectN <= reqWpHigh;
			end
			if (reqValid && reqReady) begin
				kind_r    <= reqKind;
				cmd_r     <= reqCmd;
				col_r     <= (reqCol > `NFC_LAST_COL) ? `NFC_LAST_COL : reqCol;
				row_r     <= reqRow;
				data_r    <= reqData;
				lastIdx_r <= (reqAddrCycles == `NFC_COL_ADDR_CYC) ? 3'd1 : 3'd4;
				if (reqKind == 2'd0 && isProgErase) begin
					progBusy_r    <= 1'b1;
					busySeen_r    <= 1'b0;
					writeProtectN <= 1'b1;
				end
			end
			case (state_r)
				ST_IDLE: begin
					// Latches and bus drop one cycle after the rising strobe
					writeStrobeN       <= 1'b1;
					outputStrobeN      <= 1'b1;
					ioOeN              <= 1'b1;
					commandLatchEnable <= 1'b0;
					addressLatchEnable <= 1'b0;
					if (reqValid && reqReady) begin
						chipSelectN <= 1'b0;
					end
				end
				ST_SETUP: begin
					// Latch enables chosen from the cycle type
					commandLatchEnable <= (kind_r == 2'd0);
					addressLatchEnable <= (kind_r == 2'd1);
					if (kind_r != 2'd3) begin
						// Command bits map I/O8 to bit 7
						ioOut <= (kind_r == 2'd0) ? cmd_r :
							(kind_r == 2'd1) ? addrByte : data_r;
						ioOeN <= 1'b0;
					end else begin
						ioOeN <= 1'b1;
					end
				end
				ST_TURN: begin
					ioOeN <= 1'b1;
				end
				ST_LOW: begin
					if (kind_r == 2'd3) begin
						outputStrobeN <= 1'b0;
					end else begin
						writeStrobeN <= 1'b0;
						ioOut        <= (kind_r == 2'd1) ? addrByte : ioOut;
					end
				end
				ST_HIGH: begin
					// Rising write strobe latches; read sampled at rising output strobe
					if (cnt_r == 3'd0) begin
						if (kind_r == 2'd3) begin
							rdData  <= ioIn;
							rdValid <= 1'b1;
						end
					end
					// Latch enables and bus hold past this edge for the device's hold time
					writeStrobeN  <= 1'b1;
					outputStrobeN <= 1'b1;
				end
				default: begin
					writeStrobeN  <= 1'b1;
					outputStrobeN <= 1'b1;
				end
			endcase
		end
	end

endmodule // nfc_host

// File: verification/nfc_checker.sv
// Concurrent checks on the NAND host controller ports
module nfc_checker (
	input wire logic       clock,              // System clock
	input wire logic       rst,                // Sync reset
	input wire logic       reqValid,           // Request strobe
	input wire logic       reqReady,           // Request taken
	input wire logic [1:0] reqKind,            // Request kind
	input wire logic [7:0] reqCmd,             // Command code
	input wire logic       rdValid,            // Read byte pulse
	input wire logic       devBusy,            // Filtered busy
	input wire logic       chipSelectN,        // Chip select
	input wire logic       commandLatchEnable, // Command latch
	input wire logic       addressLatchEnable, // Address latch
	input wire logic       writeStrobeN,       // Write strobe
	input wire logic       outputStrobeN,      // Output strobe
	input wire logic       writeProtectN,      // Write protect
	input wire logic [7:0] ioOut,              // Bus byte out
	input wire logic       ioOeN               // Bus enable, low drives
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// --------------------------------
	// Address byte counter
	// --------------------------------
	logic [2:0] addrCnt_r; // Bytes latched in this burst
	logic       weLast_r;  // Strobe one edge ago
	// Counter clears whenever address latch drops, so bursts never merge
	always @(posedge clock) begin
		weLast_r <= writeStrobeN;
		if (rst || !addressLatchEnable)
			addrCnt_r <= 3'h0;
		else if (writeStrobeN && !weLast_r)
			addrCnt_r <= addrCnt_r + 3'h1;
	end
	cmd_decode_a: assert property (
		$rose(writeStrobeN) && commandLatchEnable |-> !addressLatchEnable && !chipSelectN
		&& outputStrobeN && !ioOeN) else $error("command latch with wrong pins");
	addr_count_a: assert property (
		$rose(writeStrobeN) && addressLatchEnable |-> addrCnt_r < 3'h5)
		else $error("more than five address bytes");
	col_high_a: assert property (
		$rose(writeStrobeN) && addressLatchEnable && addrCnt_r == 3'h1 |-> ioOut[7:5] == 3'h0)
		else $error("column high byte upper lines set");
	row_top_a: assert property (
		$rose(writeStrobeN) && addressLatchEnable && addrCnt_r == 3'h4 |-> ioOut[7:1] == 7'h00)
		else $error("row top byte upper lines set");
	bus_fight_a: assert property (
		!outputStrobeN |-> ioOeN && !commandLatchEnable && !addressLatchEnable)
		else $error("host drives while device outputs");
	busy_refuse_a: assert property (
		devBusy && reqValid && !(reqKind == 2'h0 && (reqCmd == 8'h70 || reqCmd == 8'h71
		|| reqCmd == 8'hff)) |-> !reqReady) else $error("request taken while busy");
	busy_read_a: assert property ($fell(outputStrobeN) |-> !devBusy)
		else $error("output strobe while busy");
	wp_hold_a: assert property (
		$rose(writeStrobeN) && commandLatchEnable && ioOut == 8'h10 |=> writeProtectN [*4])
		else $error("write protect low after confirm");
	rd_pulse_a: assert property (
		rdValid |-> outputStrobeN && !$past(outputStrobeN, 1))
		else $error("read byte without output strobe");
endmodule // nfc_checker

bind nfc_host nfc_checker u_nfc_checker (.clock(clock), .rst(rst), .reqValid(reqValid),
	.reqReady(reqReady), .reqKind(reqKind), .reqCmd(reqCmd), .rdValid(rdValid),
	.devBusy(devBusy), .chipSelectN(chipSelectN), .commandLatchEnable(commandLatchEnable),
	.addressLatchEnable(addressLatchEnable), .writeStrobeN(writeStrobeN),
	.outputStrobeN(outputStrobeN), .writeProtectN(writeProtectN), .ioOut(ioOut), .ioOeN(ioOeN));

// File: verification/nfc_dev_model.sv
// Behavioural NAND device answering the host controller
module nfc_dev_model #(
	parameter int BUSY_CYC = 24 // Busy length in clocks, shortened
) (
	input wire logic       clock,  // Timebase for busy and the last-bus sample
	input wire logic       csN,    // Chip select
	input wire logic       cmdLat, // Command latch
	input wire logic       adrLat, // Address latch
	input wire logic       wrStbN, // Write strobe
	input wire logic       rdStbN, // Output strobe
	input wire logic       wpN,    // Write protect
	input wire logic [7:0] ioOut,  // Host byte
	input wire logic       ioOeN,  // Host drives when low
	output logic [7:0]     ioIn,   // Bus level seen by host
	output logic           rbN     // Ready, low when busy
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0]  page [0:4351];
	logic [7:0]  adrB [0:4];      // Address bytes
	logic [7:0]  lastCmd = 8'h00;
	logic [12:0] col = 13'h0;     // Column pointer
	logic [16:0] row = 17'h0;
	logic        statMode = 1'b0; // Status output selected
	logic [7:0]  dout = 8'h00;    // Output byte
	logic [7:0]  lastBus = 8'h00; // Bus one clock ago
	int          adrIdx = 0, busyCnt = 0, progCnt = 0, eraseCnt = 0;
	wire         drv = !csN && !cmdLat && !adrLat && !rdStbN;
	initial for (int i = 0; i < 4352; i++) page[i] = i[7:0] ^ 8'h5a;
	assign rbN = (busyCnt == 0);
	// Released bus shows the inverse of its last level: no pull on it
	assign ioIn = drv ? dout : (!ioOeN ? ioOut : ~lastBus);
	always @(posedge clock) begin
		if (busyCnt > 0) busyCnt--;
		lastBus <= ioIn;
	end
	task automatic command(input logic [7:0] c);
		lastCmd = c;
		statMode = (c == 8'h70 || c == 8'h71);
		case (c)
			8'h00, 8'h05, 8'h60, 8'h80, 8'h81, 8'h85, 8'h8c: adrIdx = 0;
			8'h30, 8'h3a: busyCnt = BUSY_CYC;
			8'h31, 8'h3f: begin
				busyCnt = BUSY_CYC;
				col = 13'h0;
			end
			8'h10, 8'h11, 8'h15, 8'hd0: if (wpN) begin
				busyCnt = BUSY_CYC;
				if (c == 8'hd0) eraseCnt++;
				else progCnt++;
			end
			8'hff: busyCnt = 0;
			default: ;
		endcase
	endtask
	// Cycle type decode on the rising write strobe
	always @(posedge wrStbN) begin
		if (!csN && rdStbN && cmdLat && !adrLat) begin
			if (busyCnt == 0 || ioOut == 8'h70 || ioOut == 8'h71 || ioOut == 8'hff)
				command(ioOut);
		end else if (!csN && rdStbN && adrLat && !cmdLat && adrIdx < 5) begin
			adrB[adrIdx] = ioOut;
			adrIdx++;
			if (adrIdx == 2) col = {adrB[1][4:0], adrB[0]};
			if (adrIdx == 5) row = {adrB[4][0], adrB[3], adrB[2]};
		end else if (!csN && rdStbN && !adrLat && !cmdLat && wpN) begin
			if (col < 13'd4352) page[col] = ioOut;
			col++;
		end
	end
	always @(negedge rdStbN) dout = statMode ? {1'b0, rbN, rbN, 5'h00} : page[col];
	always @(posedge rdStbN) if (!csN && !cmdLat && !adrLat && !statMode) col++;
endmodule // nfc_dev_model

// File: verification/tb_top.sv
// Self-checking bench for the NAND host controller
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock = 1'b0, rst = 1'b1, reqValid = 1'b0, reqWpHigh = 1'b1;
	logic [1:0]  reqKind = 2'h0;
	logic [7:0]  reqCmd = 8'h00, reqData = 8'h00, rdData, ioIn, ioOut;
	logic [12:0] reqCol = 13'h0;
	logic [16:0] reqRow = 17'h0;
	logic [2:0]  reqAddrCycles = 3'h5;
	logic        reqReady, rdValid, busyErr, csN, cle, ale, wrN, rdN, wpN, ioOeN, rbN, devBusy;
	int          errors = 0, cmp_count = 0, expProg = 0;
	always #12.5 clock = ~clock;
	nfc_host u_nfc_host (.clock(clock), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
		.reqKind(reqKind), .reqCmd(reqCmd), .reqCol(reqCol), .reqRow(reqRow),
		.reqAddrCycles(reqAddrCycles), .reqData(reqData), .reqWpHigh(reqWpHigh),
		.rdData(rdData), .rdValid(rdValid), .busyErr(busyErr), .chipSelectN(csN),
		.commandLatchEnable(cle), .addressLatchEnable(ale), .writeStrobeN(wrN),
		.outputStrobeN(rdN), .writeProtectN(wpN), .ioIn(ioIn), .ioOut(ioOut),
		.ioOeN(ioOeN), .readyBusyN(rbN), .devBusy(devBusy));
	nfc_dev_model u_nfc_dev_model (.clock(clock), .csN(csN), .cmdLat(cle), .adrLat(ale),
		.wrStbN(wrN), .rdStbN(rdN), .wpN(wpN), .ioOut(ioOut), .ioOeN(ioOeN), .ioIn(ioIn),
		.rbN(rbN));
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic hang(input int n); // Bound used up ends the run
		if (n >= 400) begin
			errors++;
			$display("[ERR] wait expected done seen timeout");
			wrap_up();
		end
	endtask
	// Request held until taken, then released just after the taking edge
	task automatic issue(input logic [1:0] k, input logic [7:0] c, input logic [7:0] d);
		int n;
		reqKind = k;
		reqCmd = c;
		reqData = d;
		reqValid = 1'b1;
		#1;
		for (n = 0; n < 400 && reqReady !== 1'b1; n++) @(posedge clock) #2;
		hang(n);
		@(posedge clock) #2;
		reqValid = 1'b0;
		@(posedge clock) #2;
		// Return once the engine is idle again, so the pin cycle has finished
		for (n = 0; n < 400 && reqReady !== 1'b1; n++) @(posedge clock) #2;
		hang(n);
	endtask
	task automatic adr(input logic [12:0] c, input logic [16:0] r, input logic [2:0] n);
		reqCol = c;
		reqRow = r;
		reqAddrCycles = n;
		issue(2'h1, 8'h00, 8'h00);
	endtask
	task automatic rd(input string what, input logic [7:0] exp);
		int n;
		issue(2'h3, 8'h00, 8'h00);
		for (n = 0; n < 400 && rdValid !== 1'b1; n++) @(posedge clock) #2;
		hang(n);
		chk(what, {8'h00, exp}, {8'h00, rdData});
	endtask
	task automatic settle(); // Busy must come, then go
		int n;
		for (n = 0; n < 40 && devBusy !== 1'b1; n++) @(posedge clock) #2;
		hang(n * 10);
		for (n = 0; n < 400 && devBusy !== 1'b0; n++) @(posedge clock) #2;
		hang(n);
	endtask
	task automatic s_read(); // Read with no setup code, then a column change
		adr(13'h0004, 17'h00041, 3'h5);
		issue(2'h0, 8'h30, 8'h00);
		settle();
		chk("block", 16'h0001, {5'h0, u_nfc_dev_model.row[16:6]});
		chk("page", 16'h0001, {10'h0, u_nfc_dev_model.row[5:0]});
		chk("column", 16'h0004, {3'h0, u_nfc_dev_model.col});
		rd("byte 4", 8'h5e);
		rd("byte 5", 8'h5f);
		issue(2'h0, 8'h05, 8'h00);
		adr(13'h10f0, 17'h0, 3'h2);
		issue(2'h0, 8'he0, 8'h00);
		chk("command bits", 16'h00e0, {8'h0, u_nfc_dev_model.lastCmd});
		rd("new column byte", 8'haa);
	endtask
	task automatic s_program(); // Clamped column, redirect, refusal while busy
		int n;
		issue(2'h0, 8'h80, 8'h00);
		adr(13'h1fff, 17'h1ffff, 3'h5);
		chk("row bit 16", 16'h0001, {15'h0, u_nfc_dev_model.row[16]});
		issue(2'h2, 8'h00, 8'ha5);
		issue(2'h0, 8'h85, 8'h00);
		adr(13'h0002, 17'h0, 3'h2);
		issue(2'h2, 8'h00, 8'h3c);
		issue(2'h2, 8'h00, 8'h3d);
		issue(2'h0, 8'h10, 8'h00);
		expProg++;
		reqWpHigh = 1'b0; // Ask for protect while busy; it must stay released
		for (n = 0; n < 40 && devBusy !== 1'b1; n++) @(posedge clock) #2;
		hang(n * 10);
		reqCmd = 8'h80;
		reqValid = 1'b1;
		repeat (2) @(posedge clock) #2;
		chk("ready while busy", 16'h0, {15'h0, reqReady});
		chk("busy refusal", 16'h1, {15'h0, busyErr});
		chk("protect during busy", 16'h1, {15'h0, wpN});
		reqValid = 1'b0;
		@(posedge clock) #2;
		issue(2'h0, 8'h70, 8'h00);
		settle();
		repeat (2) @(posedge clock) #2;
		chk("protect after busy", 16'h0, {15'h0, wpN});
		reqWpHigh = 1'b1;
		@(posedge clock) #2;
		rd("status", 8'h60);
		chk("last column", 16'h00a5, {8'h0, u_nfc_dev_model.page[4351]});
		chk("moved column", 16'h3d3c, {u_nfc_dev_model.page[3], u_nfc_dev_model.page[2]});
	endtask
	task automatic s_codes(); // Nine two-cycle pairs and the cache read codes
		logic [15:0] seq [9] = '{16'h60d0, 16'h8015, 16'h8011, 16'h8110, 16'h8115,
			16'h003a, 16'h8c15, 16'h8c10, 16'h0030};
		for (int i = 0; i < 9; i++) begin
			issue(2'h0, seq[i][15:8], 8'h00);
			adr(13'h0, 17'h00080 + 17'(i), 3'h5);
			if (seq[i][15:8] != 8'h60 && seq[i][15:8] != 8'h00)
				issue(2'h2, 8'h00, 8'h11);
			issue(2'h0, seq[i][7:0], 8'h00);
			settle();
			chk("confirm code", {8'h0, seq[i][7:0]}, {8'h0, u_nfc_dev_model.lastCmd});
			if (seq[i][7:4] == 4'h1) expProg++;
		end
		issue(2'h0, 8'h31, 8'h00);
		settle();
		issue(2'h0, 8'h3f, 8'h00);
		settle();
		rd("cache page byte", 8'h11);
		issue(2'h0, 8'h71, 8'h00);
		rd("plane status", 8'h60);
		issue(2'h0, 8'hff, 8'h00);
		chk("programs", expProg[15:0], u_nfc_dev_model.progCnt[15:0]);
		chk("erases", 16'h1, u_nfc_dev_model.eraseCnt[15:0]);
	endtask
	initial begin
		repeat (3) @(posedge clock);
		#2 rst = 1'b0;
		@(posedge clock) #2;
		s_read();
		s_program();
		s_codes();
		wrap_up();
	end
endmodule // tb_top
